// ==== verilog/rtv_top.v ====
// Purpose: Table-valid control bits, routing tables and lookups behind APB.
// Assumes: Capability straps are static; requests synchronous to mclk.
// Notes: Lookup results appear two cycles after the index is presented.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "rtv_defines.vh"
module rtv_top (
  input wire mclk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] multiport_capability,
  input wire has_request_agent,
  input wire has_port_forwarding,
  input wire has_home_expansion,
  input wire [3:0] agent_lookup_idx,
  input wire snoop_response_lookup,
  output reg agent_hit,
  output reg [7:0] target_identifier,
  input wire [3:0] request_lookup_idx,
  output reg request_hit,
  output reg request_to_egress,
  input wire [3:0] home_lookup_idx,
  output reg home_hit,
  output reg home_remote,
  output reg discovery_ready_flag,
  output reg [7:0] static_target_identifier
);
  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg [7:0] ctrl_reg;
  wire agent_map_table_valid = ctrl_reg[`RTV_BIT_AGT];
  wire request_side_map_valid = ctrl_reg[`RTV_BIT_RSM];
  wire home_side_map_valid = ctrl_reg[`RTV_BIT_HSM];
  wire mesh_operation_enable = ctrl_reg[`RTV_BIT_MESH];
  wire srm_present = (multiport_capability == `RTV_MP_ALL);
  wire rsm_present = has_request_agent | has_port_forwarding;
  wire hsm_present = has_home_expansion | has_port_forwarding;
  wire srm_valid = agent_map_table_valid & srm_present;

  wire acc = psel & penable;
  // Writes land on the edge that completes the transfer, not the first access edge
  wire wr = acc & pwrite & pready;

  function in_tbl;
    input [11:0] a;
    input [11:0] base;
    begin
      in_tbl = (a[11:6] == base[11:6]);
    end
  endfunction

  wire wr_agt = wr & in_tbl(paddr, `RTV_AGT_BASE);
  wire wr_srm = wr & in_tbl(paddr, `RTV_SRM_BASE) & srm_present;
  wire wr_rsm = wr & in_tbl(paddr, `RTV_RSM_BASE) & rsm_present;
  wire wr_hsm = wr & in_tbl(paddr, `RTV_HSM_BASE) & hsm_present;
  wire [3:0] widx = paddr[5:2];

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `RTV_CTRL_RST;
    end else if (wr && paddr == `RTV_CTRL_ADDR) begin
      // Software rising edges on bits 5..7 announce a finished table
      ctrl_reg[`RTV_BIT_AGT] <= pwdata[`RTV_BIT_AGT];
      ctrl_reg[`RTV_BIT_RSM] <= pwdata[`RTV_BIT_RSM] & rsm_present;
      ctrl_reg[`RTV_BIT_HSM] <= pwdata[`RTV_BIT_HSM] & hsm_present;
      ctrl_reg[`RTV_BIT_MESH] <= pwdata[`RTV_BIT_MESH] & multiport_capability[2];
    end
  end

  // ----------------------------------------
  // Tables
  // ----------------------------------------
  wire [31:0] agt_rd, srm_rd, rsm_rd, hsm_rd;
  wire [31:0] agt_lk, srm_lk, rsm_lk, hsm_lk;
  reg pool_scan_reg;
  reg [3:0] scan_idx_reg;
  // The pool scan borrows the register read port of the agent table
  wire [3:0] agt_ridx = pool_scan_reg ? scan_idx_reg : widx;
  rtv_table_mem u_agt (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_agt), .wr_idx(widx),
    .wr_data(pwdata), .rd_idx(agt_ridx), .rd_data(agt_rd), .lk_idx(agent_lookup_idx),
    .lk_data(agt_lk));
  rtv_table_mem u_srm (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_srm), .wr_idx(widx),
    .wr_data(pwdata), .rd_idx(widx), .rd_data(srm_rd), .lk_idx(agent_lookup_idx),
    .lk_data(srm_lk));
  rtv_table_mem u_rsm (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_rsm), .wr_idx(widx),
    .wr_data(pwdata), .rd_idx(widx), .rd_data(rsm_rd), .lk_idx(request_lookup_idx),
    .lk_data(rsm_lk));
  rtv_table_mem u_hsm (.mclk(mclk), .sys_rst(sys_rst), .wr_en(wr_hsm), .wr_idx(widx),
    .wr_data(pwdata), .rd_idx(widx), .rd_data(hsm_rd), .lk_idx(home_lookup_idx),
    .lk_data(hsm_lk));

  // ----------------------------------------
  // Discovery ready
  // ----------------------------------------
  wire rdy;
  rtv_ready_ctl u_rdy (.mclk(mclk), .sys_rst(sys_rst),
    .tbl_valid({home_side_map_valid, request_side_map_valid, agent_map_table_valid}),
    .tbl_need({hsm_present, rsm_present, 1'b1}), .ready_reg(rdy));

  // ----------------------------------------
  // Lookups
  // ----------------------------------------
  // Snoop select is delayed one cycle to line up with the registered table data
  reg snp_d_reg;
  reg agt_v_d_reg;
  reg [7:0] stat_tgt_next;
  reg [3:0] scan_seen_reg;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      snp_d_reg <= 1'b0;
      agt_v_d_reg <= 1'b0;
      agent_hit <= 1'b0;
      target_identifier <= 8'h00;
      request_hit <= 1'b0;
      request_to_egress <= 1'b0;
      home_hit <= 1'b0;
      home_remote <= 1'b0;
      discovery_ready_flag <= 1'b0;
    end else begin
      snp_d_reg <= snoop_response_lookup & mesh_operation_enable & srm_present;
      agt_v_d_reg <= agent_map_table_valid;
      discovery_ready_flag <= rdy;
      if (snp_d_reg) begin
        agent_hit <= srm_valid & srm_lk[31];
        target_identifier <= srm_lk[7:0];
      end else begin
        agent_hit <= agent_map_table_valid & agt_lk[31];
        target_identifier <= agt_lk[7:0];
      end
      request_hit <= request_side_map_valid & rsm_lk[31];
      request_to_egress <= rsm_lk[8];
      home_hit <= home_side_map_valid & hsm_lk[31];
      home_remote <= hsm_lk[8];
    end
  end

  // Static target pick: first valid agent entry of 0..14, after the stale APB-index read, held one cycle in stat_hold_reg; rescanned after each rise of bit 5
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pool_scan_reg <= 1'b0;
      scan_idx_reg <= 4'h0;
      scan_seen_reg <= 4'h0;
      static_target_identifier <= 8'h00;
    end else if (agent_map_table_valid && !agt_v_d_reg) begin
      pool_scan_reg <= 1'b1;
      scan_idx_reg <= 4'h0;
      scan_seen_reg <= 4'h0;
    end else if (pool_scan_reg) begin
      scan_idx_reg <= scan_idx_reg + 4'h1;
      scan_seen_reg <= scan_idx_reg;
      if (scan_idx_reg == 4'hf) begin
        pool_scan_reg <= 1'b0;
      end
    end
  end

  // Pool scan reads through the APB port of the agent table, taking it over whenever the scan runs
  reg scan_hit_reg;
  reg [31:0] scan_word;
  wire [31:0] agt_lk_scan = scan_word;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_hit_reg <= 1'b0;
    end else if (agent_map_table_valid && !agt_v_d_reg) begin
      scan_hit_reg <= 1'b0;
    end else if (pool_scan_reg && !scan_hit_reg && agt_lk_scan[31]) begin
      scan_hit_reg <= 1'b1;
    end
  end
  always @* begin
    scan_word = 32'h00000000;
    stat_tgt_next = static_target_identifier;
    if (pool_scan_reg && !scan_hit_reg) begin
      scan_word = agt_rd;
      if (agt_rd[31]) begin
        stat_tgt_next = agt_rd[7:0];
      end
    end
  end
  reg [7:0] stat_hold_reg;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_hold_reg <= 8'h00;
    end else begin
      stat_hold_reg <= stat_tgt_next;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Table reads need a wait state because table read data is registered
  reg rd_wait_reg;
  wire is_tbl = in_tbl(paddr, `RTV_AGT_BASE) | in_tbl(paddr, `RTV_SRM_BASE) |
    in_tbl(paddr, `RTV_RSM_BASE) | in_tbl(paddr, `RTV_HSM_BASE);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_wait_reg <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        rd_wait_reg <= 1'b0;
      end else if (acc && !pready) begin
        if (!pwrite && is_tbl && !rd_wait_reg) begin
          rd_wait_reg <= 1'b1;
        end else begin
          pready <= 1'b1;
          prdata <= 32'h00000000;
          if (paddr == `RTV_CTRL_ADDR) begin
            prdata <= {24'h000000, ctrl_reg};
          end else if (paddr == `RTV_STAT_ADDR) begin
            prdata <= {23'h000000, scan_hit_reg, stat_hold_reg[7:0] & 8'hff} & 32'h000001ff;
          end else if (in_tbl(paddr, `RTV_AGT_BASE)) begin
            prdata <= agt_rd;
          end else if (in_tbl(paddr, `RTV_SRM_BASE)) begin
            prdata <= srm_rd;
          end else if (in_tbl(paddr, `RTV_RSM_BASE)) begin
            prdata <= rsm_rd;
          end else if (in_tbl(paddr, `RTV_HSM_BASE)) begin
            prdata <= hsm_rd;
          end else begin
            pslverr <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ==== verilog/rtv_defines.vh ====
// Purpose: Constants for the routing table valid control block.
// Assumes: APB, 32-bit data, word-aligned registers.
// Notes: Tables are 16 entries each.
`ifndef RTV_DEFINES_VH
`define RTV_DEFINES_VH
`define RTV_CTRL_ADDR 12'h004
`define RTV_STAT_ADDR 12'h008
`define RTV_AGT_BASE 12'h100
`define RTV_SRM_BASE 12'h140
`define RTV_RSM_BASE 12'h180
`define RTV_HSM_BASE 12'h1c0
`define RTV_BIT_MESH 2
`define RTV_BIT_AGT 5
`define RTV_BIT_RSM 6
`define RTV_BIT_HSM 7
`define RTV_CTRL_RST 8'h00
`define RTV_MP_ALL 3'h7
`define RTV_SETTLE_NS 100
`define RTV_SETTLE_CYC ((`RTV_SETTLE_NS + 4) / 5)
`endif

// ==== verilog/rtv_table_mem.v ====
// Purpose: 16-entry table, registered read port and registered lookup.
// Assumes: Entry bit 31 is the entry valid bit, low bits carry the mapping.
// Notes: Lookup index compared to entry bits [3:0] is done by direct index.
`timescale 1ns/1ps
module rtv_table_mem (
  input wire mclk,
  input wire sys_rst,
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [3:0] rd_idx,
  output reg [31:0] rd_data,
  input wire [3:0] lk_idx,
  output reg [31:0] lk_data
);
  reg [31:0] mem [0:15];
  integer i;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[i] <= 32'h00000000;
      end
      rd_data <= 32'h00000000;
      lk_data <= 32'h00000000;
    end else begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
      lk_data <= mem[lk_idx];
    end
  end
endmodule

// ==== verilog/rtv_ready_ctl.v ====
// Purpose: Discovery-ready flag control from table-valid transitions.
// Assumes: Inputs are the registered table-valid bits.
// Notes: Ready needs all present tables valid, then a settle count.
`timescale 1ns/1ps
`include "rtv_defines.vh"
module rtv_ready_ctl (
  input wire mclk,
  input wire sys_rst,
  input wire [2:0] tbl_valid,
  input wire [2:0] tbl_need,
  output reg ready_reg
);
  localparam [7:0] SETTLE_CNT = `RTV_SETTLE_CYC;
  reg [2:0] prev_reg;
  reg [7:0] cnt_reg;
  wire rise = |(tbl_valid & ~prev_reg);
  wire fall = |(~tbl_valid & prev_reg);
  wire all_ok = &(tbl_valid | ~tbl_need);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_reg <= 3'h0;
      cnt_reg <= 8'h00;
      ready_reg <= 1'b0;
    end else begin
      prev_reg <= tbl_valid;
      if (fall || !all_ok) begin
        // Dropping on a fall is allowed, taken so lookups never race a rebuild
        ready_reg <= 1'b0;
        cnt_reg <= 8'h00;
      end else if (rise) begin
        ready_reg <= 1'b0;
        cnt_reg <= SETTLE_CNT;
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else begin
        ready_reg <= 1'b1;
      end
    end
  end
endmodule

// ==== tb/rtv_top_monitor.sv ====
// Purpose: Port assertions for the routing table valid control block.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Ready timing is judged against completed control writes.
`timescale 1ns/1ps
module rtv_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire agent_hit,
  input wire request_hit,
  input wire home_hit,
  input wire discovery_ready_flag,
  input wire [7:0] static_target_identifier
);
  // ----------------------------------------
  // Cycles since the last control write
  // ----------------------------------------
  reg [5:0] quiet_reg;
  reg wrote_reg;
  wire ctrl_wr = pready && psel && penable && pwrite && (paddr == 12'h004);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_reg <= 6'h3f;
      wrote_reg <= 1'b0;
    end else if (ctrl_wr) begin
      quiet_reg <= 6'h00;
      wrote_reg <= 1'b1;
    end else if (quiet_reg != 6'h3f) begin
      quiet_reg <= quiet_reg + 6'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ready_settle_a: assert property ($rose(discovery_ready_flag) |-> quiet_reg >= 6'h12)
    else $error("ready rose too soon after a control write");
  ready_drop_a: assert property ($fell(discovery_ready_flag) |-> quiet_reg <= 6'h04)
    else $error("ready fell without a recent control write");
  idle_miss_a: assert property (!wrote_reg |-> !(agent_hit || request_hit || home_hit))
    else $error("lookup hit before any table was validated");
  static_pick_a: assert property (static_target_identifier == 8'h00)
    else $error("static target pick not zero");
  ctrl_ok_a: assert property (pready && (paddr == 12'h004) |-> !pslverr)
    else $error("control access refused");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  answer_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
endmodule

bind rtv_top rtv_monitor u_rtv_monitor (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .agent_hit(agent_hit), .request_hit(request_hit), .home_hit(home_hit),
  .discovery_ready_flag(discovery_ready_flag),
  .static_target_identifier(static_target_identifier));

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the routing table valid control block.
// Assumes: All three tables present, multiport capability 111b.
// Notes: Straps are static, so absent-table cases are not reached.
`timescale 1ns/1ps
module testbench;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] lk_idx = 4'h0;
  reg snoop_lk = 1'b0;
  reg lk_go = 1'b0;
  reg [2:0] lk_sh = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, agent_hit, request_hit, request_to_egress, home_hit, home_remote;
  wire ready_flag;
  wire [7:0] tgt;
  reg [33:0] apb_q[$];
  reg [12:0] lk_q[$];
  reg [33:0] an;
  reg [12:0] ln;
  reg [31:0] tbl [0:3][0:3];
  reg [7:0] ctrl = 8'h00;
  integer failures = 0;
  integer checked = 0;
  integer t, i, s;
  always #2.5 mclk = ~mclk;
  rtv_top u_rtv_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .multiport_capability(3'h7), .has_request_agent(1'b1),
    .has_port_forwarding(1'b1), .has_home_expansion(1'b1), .agent_lookup_idx(lk_idx),
    .snoop_response_lookup(snoop_lk), .agent_hit(agent_hit), .target_identifier(tgt),
    .request_lookup_idx(lk_idx), .request_hit(request_hit),
    .request_to_egress(request_to_egress), .home_lookup_idx(lk_idx), .home_hit(home_hit),
    .home_remote(home_remote), .discovery_ready_flag(ready_flag),
    .static_target_identifier());
  // ----------------------------------------
  // Drivers and checks
  // ----------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] v);
    begin
      checked = checked + 1;
      if (e !== v) begin
        failures = failures + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, v);
      end
    end
  endtask
  // Note bit 33 asks for a data compare, bit 32 is the expected pslverr
  task apb(input wr, input [11:0] a, input [31:0] d, input [33:0] note);
    begin
      apb_q.push_back(note);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (!pready) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task look(input [1:0] ix, input sr);
    reg [31:0] a;
    begin
      a = (sr && ctrl[2]) ? tbl[1][ix] : tbl[0][ix];
      lk_q.push_back({ctrl[5] & a[31], a[7:0], ctrl[6] & tbl[2][ix][31], tbl[2][ix][8],
        ctrl[7] & tbl[3][ix][31], tbl[3][ix][8]});
      lk_idx <= {2'b00, ix};
      snoop_lk <= sr;
      lk_go <= 1'b1;
      @(posedge mclk);
      lk_go <= 1'b0;
      repeat (5) @(posedge mclk);
    end
  endtask
  task sweep(input sr);
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) look(k[1:0], sr);
    end
  endtask
  task final_report;
    begin
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    lk_sh <= {lk_sh[1:0], lk_go};
    if (pready) begin
      an = apb_q.pop_front();
      if (an[33]) chk("prdata", an[31:0], prdata);
      chk("pslverr", {31'h0, an[32]}, {31'h0, pslverr});
    end
    if (lk_sh[2]) begin
      ln = lk_q.pop_front();
      chk("agent_hit", {31'h0, ln[12]}, {31'h0, agent_hit});
      if (ln[12]) chk("target", {24'h0, ln[11:4]}, {24'h0, tgt});
      chk("request_hit", {31'h0, ln[3]}, {31'h0, request_hit});
      if (ln[3]) chk("egress", {31'h0, ln[2]}, {31'h0, request_to_egress});
      chk("home_hit", {31'h0, ln[1]}, {31'h0, home_hit});
      if (ln[1]) chk("remote", {31'h0, ln[0]}, {31'h0, home_remote});
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    s = $urandom(32'hbcd9);
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0, {2'b10, 32'h0});
    apb(1'b0, 12'h020, 32'h0, {2'b01, 32'h0});
    for (t = 0; t < 4; t = t + 1) begin
      for (i = 0; i < 4; i = i + 1) begin
        tbl[t][i] = $urandom & 32'h800001ff;
        if (i == 0) tbl[t][i][31] = 1'b1;
        apb(1'b1, {4'h1, t[1:0], 2'b00, i[1:0], 2'b00}, tbl[t][i], 34'h0);
      end
      apb(1'b0, {4'h1, t[1:0], 6'h04}, 32'h0, {2'b10, tbl[t][1]});
    end
    sweep(1'b0);
    for (i = 5; i < 8; i = i + 1) begin
      ctrl[i] = 1'b1;
      apb(1'b1, 12'h004, {24'h0, ctrl}, 34'h0);
      chk("ready", 32'h0, {31'h0, ready_flag});
    end
    repeat (30) @(posedge mclk);
    chk("ready", 32'h1, {31'h0, ready_flag});
    sweep(1'b0);
    sweep(1'b1);
    ctrl[2] = 1'b1;
    apb(1'b1, 12'h004, {24'h0, ctrl}, 34'h0);
    sweep(1'b1);
    ctrl[6] = 1'b0;
    apb(1'b1, 12'h004, {24'h0, ctrl}, 34'h0);
    repeat (3) @(posedge mclk);
    chk("ready", 32'h0, {31'h0, ready_flag});
    apb(1'b0, 12'h004, 32'h0, {2'b10, 24'h0, ctrl});
    sweep(1'b0);
    chk("queues", 32'h0, apb_q.size() + lk_q.size());
    final_report;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures = failures + 1;
    final_report;
  end
endmodule
